// ==== afc_regs.vh ====
`ifndef AFC_REGS_VH
`define AFC_REGS_VH

// register map
`define AFC_CONFIG_ADDR 12'h0ac
`define AFC_STATUS_ADDR 12'h0b4
`define AFC_ADDR_W 12

// configuration fields
`define AFC_HIGH_MSB 23
`define AFC_HIGH_LSB 16
`define AFC_LOW_MSB 15
`define AFC_LOW_LSB 8
`define AFC_DUR_MSB 7
`define AFC_DUR_LSB 4
`define AFC_MULT_BIT 3
`define AFC_BRD_BIT 2
`define AFC_ADD_BIT 1
`define AFC_ANY_BIT 0
`define AFC_CONFIG_MASK 32'h00ffffff
`define AFC_CONFIG_RESET 32'h00000000

// threshold unit is 64 bytes
`define AFC_UNIT_SHIFT 6

// jam time base in 20 ns clock cycles
`define AFC_STEP_CYC 19'h000fa
`define AFC_EXTRA10_CYC 19'h0006e

`endif

// ==== afc_trigger.v ====
`timescale 1ns/1ps
`default_nettype none
`include "afc_regs.vh"

// Summary of operation
// (RULE1) transmitter off: no pause, no jam
// (RULE2) high threshold bits 23:16, 64-byte units
// (RULE3) full duplex: one pause frame at high
// (RULE4) half duplex: jam matching frames after high
// (RULE5) low threshold 15:8; below sends zero pause
// (RULE6) zero pause only after high pause sent
// (RULE7) software keeps low below high
// (RULE8) duration bits 7:4, unused in full duplex
// (RULE9) bit 3 jams multicast frames
// (RULE10) bit 2 jams broadcast frames
// (RULE11) bit 1 jams own-address frames
// (RULE12) fields reset zero, top byte reads zero
// (RULE13) bit 0 any frame, overrides bits 3:1
// (RULE14) duration code maps 5 us to 600 us
// (RULE15) full-duplex pause needs any-frame bit
// (RULE16) high at count >= hi*64; rearm after zero
module afc_trigger #(
  parameter FILL_W = 14
)(
  // clock and reset
  input wire clk_sys,
  input wire rst_b,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // mac status
  input wire tx_enable,
  input wire full_duplex,
  input wire speed_100,
  input wire [FILL_W-1:0] rx_fill_bytes,
  // receive frame events
  input wire rx_preamble,
  input wire rx_is_multicast,
  input wire rx_is_broadcast,
  input wire rx_is_own_addr,
  // pause request to mac transmitter
  input wire [15:0] pause_time_value,
  output reg pause_req,
  output reg [15:0] pause_time,
  input wire pause_done,
  // half duplex back pressure
  output reg jam_active
);

  // configuration and episode state
  reg [31:0] flow_control_config;
  reg high_seen;
  reg pause_sent;
  reg [2:0] pend;

  // pause episode states, one-hot
  localparam PEND_IDLE = 3'b001;
  localparam PEND_HIGH = 3'b010;
  localparam PEND_ZERO = 3'b100;

  // back-pressure timing
  reg [18:0] jam_cnt;
  reg [7:0] jam_steps;
  reg [18:0] next_jam_len;

  // thresholds scaled to bytes
  reg [FILL_W+1:0] hi_bytes;
  reg [FILL_W+1:0] lo_bytes;

  // field views of the configuration word
  wire [7:0] fill_high_threshold;
  wire [7:0] fill_low_threshold;
  wire [3:0] jam_duration_code;
  wire trigger_on_multicast;
  wire trigger_on_broadcast;
  wire trigger_on_own_address;
  wire trigger_on_any_frame;

  // level compares, frame decode and bus strobe
  wire at_high;
  wire below_low;
  wire auto_on;
  wire [2:0] class_sel;
  wire [2:0] class_seen;
  wire [2:0] class_hit;
  wire frame_match;
  wire apb_acc;
  wire [31:0] status_word;

  // field views of the configuration word
  assign fill_high_threshold =
    flow_control_config[`AFC_HIGH_MSB:`AFC_HIGH_LSB];  // see RULE2
  assign fill_low_threshold =
    flow_control_config[`AFC_LOW_MSB:`AFC_LOW_LSB];  // see RULE5
  assign jam_duration_code =
    flow_control_config[`AFC_DUR_MSB:`AFC_DUR_LSB];  // see RULE8
  assign trigger_on_multicast = flow_control_config[`AFC_MULT_BIT];
  assign trigger_on_broadcast = flow_control_config[`AFC_BRD_BIT];
  assign trigger_on_own_address = flow_control_config[`AFC_ADD_BIT];
  assign trigger_on_any_frame = flow_control_config[`AFC_ANY_BIT];
  // any selection bit arms the high-level watch
  assign auto_on = |flow_control_config[`AFC_MULT_BIT:`AFC_ANY_BIT];

  // thresholds in bytes, two bits wider than the fill count so
  // 255 * 64 never wraps; compare is on bytes, not 64-byte units
  always @*
  begin
    hi_bytes = {{(FILL_W-6){1'b0}}, fill_high_threshold} <<
      `AFC_UNIT_SHIFT;
    lo_bytes = {{(FILL_W-6){1'b0}}, fill_low_threshold} <<
      `AFC_UNIT_SHIFT;
  end
  assign at_high = {2'b00, rx_fill_bytes} >= hi_bytes;  // see RULE16
  assign below_low = {2'b00, rx_fill_bytes} < lo_bytes;  // see RULE5

  // per-class selection; any-frame bit overrides the per-type bits
  assign class_sel = {trigger_on_multicast,  // see RULE9
    trigger_on_broadcast,  // see RULE10
    trigger_on_own_address};  // see RULE11
  assign class_seen = {rx_is_multicast, rx_is_broadcast, rx_is_own_addr};
  // one gate per class bit
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_class
      assign class_hit[gi] = class_sel[gi] & class_seen[gi];
    end
  endgenerate
  assign frame_match = trigger_on_any_frame | (|class_hit);  // see RULE13

  // jam length in cycles, looked up in 5 us steps; 10 Mb/s adds a
  // fixed 2.2 us to every code; the longest, 120 steps plus the
  // extra, still fits the 19-bit counter, so no code is refused
  // and none wraps
  always @*
  begin
    case (jam_duration_code)  // see RULE14
      4'h0: jam_steps = 8'h01;
      4'h1: jam_steps = 8'h02;
      4'h2: jam_steps = 8'h03;
      4'h3: jam_steps = 8'h05;
      4'h4: jam_steps = 8'h0a;
      4'h5: jam_steps = 8'h14;
      4'h6: jam_steps = 8'h1e;
      4'h7: jam_steps = 8'h28;
      4'h8: jam_steps = 8'h32;
      4'h9: jam_steps = 8'h3c;
      4'ha: jam_steps = 8'h46;
      4'hb: jam_steps = 8'h50;
      4'hc: jam_steps = 8'h5a;
      4'hd: jam_steps = 8'h64;
      4'he: jam_steps = 8'h6e;
      default: jam_steps = 8'h78;
    endcase
    next_jam_len = {11'h000, jam_steps} * `AFC_STEP_CYC;
    if (!speed_100)
      next_jam_len = next_jam_len + `AFC_EXTRA10_CYC;
  end

  // apb: one access cycle, no wait states; read data is latched in
  // the setup cycle so it stands through the access cycle; unmapped
  // reads give zero with an error, and writes there are dropped
  assign apb_acc = psel & penable;
  // status word: live compare, episode flags and both outputs
  assign status_word = {27'h0000000, jam_active, pause_req, pause_sent,
    high_seen, at_high};
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      flow_control_config <= `AFC_CONFIG_RESET;  // see RULE12
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel & ~penable)
      begin
        if (paddr == `AFC_CONFIG_ADDR)
          prdata <= flow_control_config;
        else if (paddr == `AFC_STATUS_ADDR)
          prdata <= status_word;
        else
          pslverr <= 1'b1;
      end
      // a write lands only at the access edge, with pready high
      if (apb_acc & pready & pwrite & (paddr == `AFC_CONFIG_ADDR))
        flow_control_config <= pwdata & `AFC_CONFIG_MASK;  // see RULE12
    end
  end

  // pause frames in full duplex, jam in half duplex
  always @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      // all outputs low, no episode open
      high_seen <= 1'b0;
      pause_sent <= 1'b0;
      pend <= PEND_IDLE;
      pause_req <= 1'b0;
      pause_time <= 16'h0000;
      jam_cnt <= 19'h00000;
      jam_active <= 1'b0;
    end
    else if (!tx_enable)
    begin
      // nothing leaves while the transmitter is off; a waiting
      // request is dropped, not carried over to the next enable
      pause_req <= 1'b0;  // see RULE1
      jam_active <= 1'b0;  // see RULE1
      jam_cnt <= 19'h00000;
      pend <= PEND_IDLE;
    end
    else
    begin
      // request held until the mac reports the frame sent
      case (pend)
        PEND_HIGH:
        begin
          if (pause_done)
          begin
            pause_req <= 1'b0;
            pause_sent <= 1'b1;  // see RULE6
            pend <= PEND_IDLE;
          end
        end
        PEND_ZERO:
        begin
          if (pause_done)
          begin
            // episode closed: re-arm for the next full level
            pause_req <= 1'b0;
            pause_sent <= 1'b0;  // see RULE16
            high_seen <= 1'b0;
            pend <= PEND_IDLE;
          end
        end
        default:
        begin
          // idle, or a stray code forced back to idle
          pend <= PEND_IDLE;
          if (full_duplex & trigger_on_any_frame)  // see RULE15
          begin
            if (at_high & ~pause_sent)
            begin
              pause_req <= 1'b1;  // see RULE3
              pause_time <= pause_time_value;
              pend <= PEND_HIGH;
            end
            else if (below_low & pause_sent)  // see RULE6
            begin
              pause_req <= 1'b1;  // see RULE5
              pause_time <= 16'h0000;
              pend <= PEND_ZERO;
            end
          end
        end
      endcase

      // half duplex jamming; duration ignored in full duplex
      if (full_duplex)
      begin
        jam_active <= 1'b0;  // see RULE8
        jam_cnt <= 19'h00000;
      end
      else if (rx_preamble & high_seen & at_high & frame_match)
      begin
        // a new matching frame restarts the full duration
        jam_active <= 1'b1;  // see RULE4
        jam_cnt <= next_jam_len;
      end
      else if (jam_cnt != 19'h00000)
      begin
        // count down; the output falls with the last count
        jam_cnt <= jam_cnt - 19'd1;
        jam_active <= (jam_cnt != 19'd1);
      end
      else
        jam_active <= 1'b0;

      // half duplex forgets the full level once it drains
      if (~at_high & ~full_duplex)
        high_seen <= 1'b0;
      // set last so a new full level beats a same-cycle clear
      if (at_high & auto_on)
        high_seen <= 1'b1;
    end
  end

endmodule

`default_nettype wire

// ==== afc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module afc_checker (
  // clock, reset and bus
  input wire logic clk_sys, rst_b, psel, penable, pwrite, pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  // flow control
  input wire logic tx_enable, full_duplex, rx_preamble,
  input wire logic pause_req, pause_done, jam_active,
  input wire logic [15:0] pause_time_value, pause_time
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence setup_s;
    psel && !penable;
  endsequence
  apb_ready_a:
    assert property (setup_s |=> pready ##1 !pready) else $error("no ready");
  top_byte_a:
    assert property (pready && !pwrite && paddr == 12'h0ac
      |-> prdata[31:24] == 8'h00) else $error("top byte set");
  tx_off_a:
    assert property (!tx_enable |=> !pause_req && !jam_active)
      else $error("active with tx off");
  pause_hold_a:
    assert property (pause_req && !pause_done && tx_enable |=> pause_req)
      else $error("request dropped");
  pause_drop_a:
    assert property (pause_req && pause_done |=> !pause_req)
      else $error("request held");
  pause_cause_a:
    assert property ($rose(pause_req) |-> $past(full_duplex)
      && (pause_time == $past(pause_time_value) || pause_time == 16'h0000))
      else $error("bad pause");
  fd_no_jam_a:
    assert property (full_duplex |=> !jam_active) else $error("jam in fd");
  jam_cause_a:
    assert property ($rose(jam_active) |-> $past(rx_preamble))
      else $error("jam no frame");
endmodule
bind afc_trigger afc_checker i_afc_checker (.clk_sys, .rst_b, .psel,
  .penable, .pwrite, .pready, .paddr, .prdata, .tx_enable, .full_duplex,
  .rx_preamble, .pause_req, .pause_done, .jam_active, .pause_time_value,
  .pause_time);
`default_nettype wire

// ==== afc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module afc_mac_model (
  // clock, reset, pacing
  input wire logic clk_sys, rst_b, slow,
  // pause request
  input wire logic pause_req,
  input wire logic [15:0] pause_time,
  // frame sent and log
  output logic pause_done,
  output logic [7:0] frames,
  output logic [15:0] last_time
);
  logic [7:0] waited;
  // one frame per request, prompt or after a slow wait
  always_ff @(posedge clk_sys)
  begin
    pause_done <= 1'b0;
    waited <= 8'h00;
    if (!rst_b)
    begin
      frames <= 8'h00;
      last_time <= 16'h0000;
    end
    else if (pause_req && !pause_done)
    begin
      waited <= waited + 8'h01;
      if (waited == (slow ? 8'h14 : 8'h00))
      begin
        pause_done <= 1'b1;
        frames <= frames + 8'h01;
        last_time <= pause_time;
      end
    end
  end
endmodule
`default_nettype wire

// ==== afc_trigger_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module afc_trigger_tb;
  logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic tx_enable = 1, full_duplex = 1, speed_100 = 1, rx_preamble = 0;
  logic rx_is_multicast = 0, rx_is_broadcast = 0, rx_is_own_addr = 0;
  logic pause_done, pready, pslverr, pause_req, jam_active, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [13:0] rx_fill_bytes = 0;
  logic [15:0] pause_time_value = 16'h1234, pause_time, last_time;
  logic [7:0] frames;
  int fails = 0, checked = 0, cyc = 0, n;
  // address, write data, read data, error
  logic [76:0] rows [3] = '{{12'h0ac, 32'hffffffff, 32'h00ffffff, 1'b0},
    {12'h0ac, 32'h5a0201f3, 32'h000201f3, 1'b0},
    {12'h0b0, 32'hffffffff, 32'h00000000, 1'b1}};
  int dur_t [4] = '{250, 500, 750, 1250};
  always #10 clk_sys = ~clk_sys;
  afc_trigger i_afc_trigger (.clk_sys, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_enable, .full_duplex,
    .speed_100, .rx_fill_bytes, .rx_preamble, .rx_is_multicast,
    .rx_is_broadcast, .rx_is_own_addr, .pause_time_value, .pause_req,
    .pause_time, .pause_done, .jam_active);
  afc_mac_model i_afc_mac_model (.clk_sys, .rst_b, .slow, .pause_req,
    .pause_time, .pause_done, .frames, .last_time);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic pulse(input logic mc, input logic bc, input logic own);
    @(posedge clk_sys);
    {rx_preamble, rx_is_multicast, rx_is_broadcast, rx_is_own_addr} <=
      {1'b1, mc, bc, own};
    @(posedge clk_sys);
    rx_preamble <= 0;
  endtask
  task automatic wrap_up;
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard, far above the expected run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    apb(0, 12'h0ac, 0);
    chk(rd, 0);
    foreach (rows[i])
    begin
      apb(1, rows[i][76:65], rows[i][64:33]);
      apb(0, rows[i][76:65], 0);
      chk(rd, rows[i][32:1]);
      chk({31'b0, err}, {31'b0, rows[i][0]});
    end
    // full duplex pause episode
    apb(1, 12'h0ac, 32'h0002010e);
    rx_fill_bytes <= 200;
    settle(30);
    chk(frames, 0);
    rx_fill_bytes <= 10;
    apb(1, 12'h0ac, 32'h00020101);
    settle(30);
    chk(frames, 0);
    rx_fill_bytes <= 127;
    settle(20);
    chk(frames, 0);
    rx_fill_bytes <= 128;
    settle(60);
    chk(frames, 1);
    chk(last_time, 16'h1234);
    rx_fill_bytes <= 100;
    slow <= 1;
    settle(40);
    chk(frames, 1);
    rx_fill_bytes <= 63;
    settle(40);
    chk(frames, 2);
    chk(last_time, 0);
    tx_enable <= 0;
    rx_fill_bytes <= 200;
    settle(30);
    chk(frames, 2);
    tx_enable <= 1;
    settle(40);
    chk(frames, 3);
    // half duplex: one selection bit and one duration code per pass
    full_duplex <= 0;
    for (int i = 0; i < 4; i++)
    begin
      rx_fill_bytes <= 0;
      speed_100 <= (i != 2);
      apb(1, 12'h0ac, 32'h00020100 | (i << 4) | (1 << i));
      rx_fill_bytes <= 200;
      settle(3);
      pulse(i != 3, i == 3, 0);
      settle(1);
      chk(jam_active, i == 0);
      settle(dur_t[i] + 120);
      pulse(i == 3, i == 2, i == 1);
      settle(1);
      n = 0;
      while (jam_active === 1'b1 && n < 2000)
      begin
        n++;
        @(posedge clk_sys);
      end
      chk(n, dur_t[i] + (i == 2 ? 110 : 0));
    end
    wrap_up;
  end
endmodule
`default_nettype wire
